// ==== supply_fault_response_alarm.sv ====
`timescale 1ns/10ps
module supply_fault_response_alarm
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [16*fault_resp_pkg::num_chan-1:0] channel_response_word_in,
    input wire logic [15:0] retry_delay_setting_in,
    input wire logic immediate_off_in,
    input wire logic alert_enable_in,
    input wire logic clear_faults_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] secondary_group_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] ov_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] ov_warn_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] uv_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] uv_warn_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] seq_fault_in,
    input wire logic [fault_resp_pkg::num_temp-1:0] ot_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] supply_request_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] off_sequence_done_in,
    output logic [fault_resp_pkg::num_chan-1:0] supply_enable_out,
    output logic primary_group_fault_out,
    output logic secondary_group_fault_pin_out,
    output logic first_alarm_out,
    output logic second_alarm_out,
    output logic alert_out,
    output logic log_write_out,
    output logic [3:0] log_kind_out,
    output logic [fault_resp_pkg::num_chan-1:0] log_chan_out,
    output logic [fault_resp_pkg::num_temp-1:0] log_sensor_out,
    output logic [fault_resp_pkg::num_chan-1:0] ov_status_out,
    output logic [fault_resp_pkg::num_chan-1:0] uv_status_out,
    output logic [fault_resp_pkg::num_chan-1:0] seq_status_out,
    output logic [fault_resp_pkg::num_temp-1:0] ot_status_out
);
    import fault_resp_pkg::*;
    localparam int nc = num_chan, nt = num_temp; // channel and sensor counts
    // response field of one channel
    function automatic logic [1:0] resp_of(input logic [16*nc-1:0] w, input int ch, input int lsb);
        resp_of = w[16*ch+lsb +: 2];
    endfunction

    // the log enable bit with an action code (anything but 00) allows logging
    function automatic logic may_log(input logic [16*nc-1:0] w, input int ch, input int lsb);
        may_log = w[16*ch+log_enable_bit] && (resp_of(w, ch, lsb) != resp_status_only);
    endfunction

    // input synchronisers
    logic [nc-1:0] ov_s1, ov_s2, ovw_s1, ovw_s2, uv_s1, uv_s2, uvw_s1, uvw_s2, sq_s1, sq_s2;
    logic [nt-1:0] ot_s1, ot_s2;
    // previous fault levels for edge detect
    logic [nc-1:0] ov_d, uv_d, sq_d;
    logic [nt-1:0] ot_d;
    // latched status and log suppression
    logic [nc-1:0] ov_st, uv_st, sq_st, next_ov_st, next_uv_st, next_sq_st;
    logic [nt-1:0] ot_st, next_ot_st;
    logic [nc-1:0] ov_mute, uv_mute, next_ov_mute, next_uv_mute;
    logic [nt-1:0] ot_mute, next_ot_mute;
    // registered outputs
    logic next_alert, next_log_write, next_first_alarm_out, next_second_alarm_out, next_pfault, next_sfault;
    logic [3:0] next_log_kind;
    logic [nc-1:0] next_log_chan, next_en;
    logic [nt-1:0] next_log_sensor;
    // global shutdown per group (0 primary, 1 secondary)
    glob_state_e gst [2];
    glob_state_e next_gst [2];
    logic [1:0] timer_start, timer_done;
    // combinational helpers
    logic [nc-1:0] ov_rise, uv_rise, sq_rise, glob;
    logic [nt-1:0] ot_rise;
    logic [1:0] grp_retry, grp_latch, grp_any_fault;

    // retry delay timers, one per group
    for (genvar g = 0; g < 2; g++)
    begin : g_timer
        retry_timer u_timer (
            .ref_clk_in(ref_clk_in),
            .rstn_in(rstn_in),
            .start_in(timer_start[g]),
            .delay_in(retry_delay_setting_in),
            .done_out(timer_done[g])
        );
    end

    // fault input synchronisers and edge history
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            {ov_s1, ov_s2, ovw_s1, ovw_s2, uv_s1, uv_s2} <= '0;
            {uvw_s1, uvw_s2, sq_s1, sq_s2, ot_s1, ot_s2} <= '0;
            {ov_d, uv_d, sq_d, ot_d} <= '0;
        end
        else
        begin
            {ov_s1, ovw_s1, uv_s1, uvw_s1, sq_s1, ot_s1} <= {ov_fault_in, ov_warn_in, uv_fault_in,
                uv_warn_in, seq_fault_in, ot_fault_in};
            {ov_s2, ovw_s2, uv_s2, uvw_s2, sq_s2, ot_s2} <= {ov_s1, ovw_s1, uv_s1, uvw_s1, sq_s1, ot_s1};
            {ov_d, uv_d, sq_d, ot_d} <= {ov_s2, uv_s2, sq_s2, ot_s2};
        end
    end

    // status, log, alert and alarm decisions
    always_comb
    begin
        ov_rise = ov_s2 & ~ov_d;
        uv_rise = uv_s2 & ~uv_d;
        sq_rise = sq_s2 & ~sq_d;
        ot_rise = ot_s2 & ~ot_d;
        // clear first, then set wins over clear
        next_ov_st = (clear_faults_in ? '0 : ov_st) | ov_rise;
        next_uv_st = (clear_faults_in ? '0 : uv_st) | uv_rise;
        next_sq_st = (clear_faults_in ? '0 : sq_st) | sq_rise;
        next_ot_st = (clear_faults_in ? '0 : ot_st) | ot_rise;
        next_alert = alert_enable_in && ((|(ov_rise & ~ov_st)) || (|(uv_rise & ~uv_st)) ||
            (|(sq_rise & ~sq_st)) || (|(ot_rise & ~ot_st)));
        next_ov_mute = clear_faults_in ? '0 : ov_mute & supply_enable_out;
        next_uv_mute = clear_faults_in ? '0 : uv_mute & supply_enable_out;
        next_ot_mute = clear_faults_in ? '0 : ot_mute;
        next_log_write = 1'b0;
        next_log_kind = 4'h0;
        next_log_chan = '0;
        next_log_sensor = '0;
        next_first_alarm_out = 1'b0;
        next_second_alarm_out = 1'b0;
        for (int c = 0; c < nc; c++)
        begin
            logic [2:0] cond;
            logic hit;
            cond = channel_response_word_in[16*c+alarm_lsb +: 3];
            hit = 1'b0;
            if (ov_rise[c] && may_log(channel_response_word_in, c, ov_resp_lsb) && !ov_mute[c])
            begin
                next_log_chan[c] = 1'b1;
                next_log_kind[0] = 1'b1;
                next_ov_mute[c] = 1'b1;
            end
            if (uv_rise[c] && may_log(channel_response_word_in, c, uv_resp_lsb) && !uv_mute[c])
            begin
                next_log_chan[c] = 1'b1;
                next_log_kind[1] = 1'b1;
                next_uv_mute[c] = 1'b1;
            end
            if (sq_rise[c] && may_log(channel_response_word_in, c, ton_resp_lsb))
            begin
                next_log_chan[c] = 1'b1;
                next_log_kind[2] = 1'b1;
            end
            // alarm condition select
            if (cond == alarm_seq)
                hit = sq_s2[c];
            else if (cond != 3'h0)
            begin
                if (cond[1])
                    hit = hit | uv_s2[c] | (cond[0] & uvw_s2[c]);
                if (cond[2])
                    hit = hit | ov_s2[c] | (cond[0] & ovw_s2[c]);
            end
            if (channel_response_word_in[16*c+alarm_msb])
                next_second_alarm_out = next_second_alarm_out | hit;
            else
                next_first_alarm_out = next_first_alarm_out | hit;
        end
        // temperature: any channel enabling the log with action code
        for (int t = 0; t < nt; t++)
        begin
            logic ok;
            ok = 1'b0;
            for (int c = 0; c < nc; c++)
                ok = ok | may_log(channel_response_word_in, c, ot_resp_lsb);
            if (ot_rise[t] && ok && !ot_mute[t])
            begin
                next_log_sensor[t] = 1'b1;
                next_log_kind[3] = 1'b1;
                next_ot_mute[t] = 1'b1;
            end
        end
        next_log_write = |next_log_kind;
    end

    // global group response decisions
    always_comb
    begin
        glob = '0;
        grp_retry = 2'b00;
        grp_latch = 2'b00;
        grp_any_fault = 2'b00;
        for (int c = 0; c < nc; c++)
        begin
            logic g;
            logic [1:0] r;
            r = 2'b00;
            glob[c] = channel_response_word_in[16*c+global_bit];
            g = secondary_group_in[c];
            grp_any_fault[g] = grp_any_fault[g] | (glob[c] & (ov_s2[c] | uv_s2[c] | sq_s2[c]));
            for (int k = 0; k < 4; k++)
            begin
                r = resp_of(channel_response_word_in, c, 2*k);
                if (glob[c] && (k == 0 ? ov_rise[c] : k == 1 ? uv_rise[c] : k == 2 ? sq_rise[c] : |ot_rise))
                begin
                    grp_retry[g] = grp_retry[g] | (r == resp_retry);
                    grp_latch[g] = grp_latch[g] | (r == resp_latch_off);
                end
            end
        end
        for (int g = 0; g < 2; g++)
        begin
            next_gst[g] = gst[g];
            timer_start[g] = 1'b0;
            case (gst[g])
                st_run:
                    if (grp_latch[g])
                        next_gst[g] = st_latched;
                    else if (grp_retry[g])
                        next_gst[g] = st_shut;
                st_shut:
                begin
                    if (grp_latch[g])
                        next_gst[g] = st_latched;
                    else if (immediate_off_in || &(off_sequence_done_in | ~glob |
                        (secondary_group_in ^ {nc{g[0]}})))
                    begin
                        next_gst[g] = st_wait;
                        timer_start[g] = 1'b1;
                    end
                end
                st_wait:
                    if (grp_latch[g])
                        next_gst[g] = st_latched;
                    else if (timer_done[g] && !grp_any_fault[g])
                        next_gst[g] = st_run;
                    else if (timer_done[g])
                        timer_start[g] = 1'b1;
                st_latched:
                    if (clear_faults_in)
                        next_gst[g] = st_run;
                default:
                    next_gst[g] = st_run;
            endcase
        end
        // enables: off while own global group is not running
        for (int c = 0; c < nc; c++)
            next_en[c] = supply_request_in[c] &&
                !(glob[c] && gst[secondary_group_in[c]] != st_run);
        next_pfault = gst[0] != st_run;
        next_sfault = gst[1] != st_run;
    end

    // register stage
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            {ov_st, uv_st, sq_st, ot_st, ov_mute, uv_mute, ot_mute} <= '0;
            gst <= '{st_run, st_run};
            {supply_enable_out, primary_group_fault_out, secondary_group_fault_pin_out} <= '0;
            {first_alarm_out, second_alarm_out, alert_out, log_write_out} <= '0;
            {log_kind_out, log_chan_out, log_sensor_out} <= '0;
        end
        else
        begin
            {ov_st, uv_st, sq_st, ot_st} <= {next_ov_st, next_uv_st, next_sq_st, next_ot_st};
            {ov_mute, uv_mute, ot_mute} <= {next_ov_mute, next_uv_mute, next_ot_mute};
            gst <= next_gst;
            supply_enable_out <= next_en;
            {primary_group_fault_out, secondary_group_fault_pin_out} <= {next_pfault, next_sfault};
            {first_alarm_out, second_alarm_out} <= {next_first_alarm_out, next_second_alarm_out};
            {alert_out, log_write_out} <= {next_alert, next_log_write};
            {log_kind_out, log_chan_out, log_sensor_out} <= {next_log_kind, next_log_chan, next_log_sensor};
        end
    end
    // status outputs straight from the latches
    assign ov_status_out = ov_st;
    assign uv_status_out = uv_st;
    assign seq_status_out = sq_st;
    assign ot_status_out = ot_st;
endmodule

// ==== fault_resp_pkg.sv ====
package fault_resp_pkg;
    // channel and sensor counts
    localparam int num_chan = 12;
    localparam int num_temp = 5;
    // response word field positions
    localparam int log_enable_bit = 15;
    localparam int global_bit = 14;
    localparam int alarm_msb = 11;
    localparam int alarm_lsb = 8;
    localparam int ot_resp_lsb = 6;
    localparam int ton_resp_lsb = 4;
    localparam int uv_resp_lsb = 2;
    localparam int ov_resp_lsb = 0;
    // response codes
    localparam logic [1:0] resp_status_only = 2'h0;
    localparam logic [1:0] resp_latch_off = 2'h1;
    localparam logic [1:0] resp_retry = 2'h2;
    localparam logic [1:0] resp_continue = 2'h3;
    // alarm condition codes (low three bits)
    localparam logic [2:0] alarm_seq = 3'h1;
    // reset values
    localparam logic [15:0] response_word_reset = 16'h0000;
    localparam logic [15:0] retry_delay_reset = 16'h0000;
    // one retry tick = 1 us at 200 MHz
    localparam int clk_mhz = 200;
    localparam int tick_ns = 1000;
    localparam int clk_period_ns = 1000 / clk_mhz;
    localparam int tick_cycles = tick_ns / clk_period_ns;
    // global shutdown states
    typedef enum logic [3:0] {
        st_run = 4'b0001,
        st_shut = 4'b0010,
        st_wait = 4'b0100,
        st_latched = 4'b1000
    } glob_state_e;
endpackage

// ==== retry_timer.sv ====
`timescale 1ns/10ps
// counts retry delay in 1 us ticks once started
module retry_timer
    import fault_resp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic start_in,
    input wire logic [15:0] delay_in,
    output logic done_out
);
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    logic [15:0] delay_cnt;
    logic [15:0] next_delay_cnt;
    logic busy;
    logic next_busy;
    logic next_done;

    // divider and delay countdown
    always_comb
    begin
        next_tick_cnt = tick_cnt;
        next_delay_cnt = delay_cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (start_in)
        begin
            next_busy = 1'b1;
            next_delay_cnt = delay_in;
            next_tick_cnt = 16'h0000;
        end
        else if (busy)
        begin
            if (delay_cnt == 16'h0000)
            begin
                // zero delay restarts at once
                next_busy = 1'b0;
                next_done = 1'b1;
            end
            else if (tick_cnt == 16'(tick_cycles - 1))
            begin
                next_tick_cnt = 16'h0000;
                next_delay_cnt = delay_cnt - 16'h0001;
            end
            else
            begin
                next_tick_cnt = tick_cnt + 16'h0001;
            end
        end
    end

    // register stage
    always_ff @(posedge ref_clk_in)
    begin
        if (!rstn_in)
        begin
            tick_cnt <= 16'h0000;
            delay_cnt <= 16'h0000;
            busy <= 1'b0;
            done_out <= 1'b0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            delay_cnt <= next_delay_cnt;
            busy <= next_busy;
            done_out <= next_done;
        end
    end
endmodule

// ==== sfra_properties.sv ====
`timescale 1ns/10ps
// port-level checks for the fault response block
module sfra_properties
    import fault_resp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [16*fault_resp_pkg::num_chan-1:0] channel_response_word_in,
    input wire logic immediate_off_in,
    input wire logic alert_enable_in,
    input wire logic clear_faults_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] secondary_group_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] ov_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] ov_warn_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] uv_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] uv_warn_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] seq_fault_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] supply_enable_out,
    input wire logic primary_group_fault_out,
    input wire logic secondary_group_fault_pin_out,
    input wire logic first_alarm_out,
    input wire logic second_alarm_out,
    input wire logic alert_out,
    input wire logic log_write_out,
    input wire logic [3:0] log_kind_out,
    input wire logic [fault_resp_pkg::num_chan-1:0] log_chan_out,
    input wire logic [fault_resp_pkg::num_temp-1:0] log_sensor_out,
    input wire logic [fault_resp_pkg::num_chan-1:0] ov_status_out,
    input wire logic [fault_resp_pkg::num_chan-1:0] uv_status_out,
    input wire logic [fault_resp_pkg::num_chan-1:0] seq_status_out,
    input wire logic [fault_resp_pkg::num_temp-1:0] ot_status_out
);
    logic [num_chan-1:0] gm; // global channels of the primary group
    logic [3*num_chan+num_temp-1:0] st; // every status bit
    logic [num_chan-1:0] raw; // any ov, uv or seq fault or warning level
    // global flag per channel, primary group only
    always_comb
    begin
        for (int c = 0; c < num_chan; c++)
        begin
            gm[c] = channel_response_word_in[16*c+global_bit] & ~secondary_group_in[c];
        end
    end
    assign st = {ov_status_out, uv_status_out, seq_status_out, ot_status_out};
    assign raw = ov_fault_in | ov_warn_in | uv_fault_in | uv_warn_in | seq_fault_in;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);
    // group fault on two edges running
    sequence fault_held;
        primary_group_fault_out ##1 primary_group_fault_out;
    endsequence
    // no ov, uv or seq fault or warning level for four edges
    sequence inputs_quiet;
        (raw == '0) [*4];
    endsequence
    status_keep_a: assert property (!clear_faults_in |=> (st & $past(st)) == $past(st))
        else $error("status bit dropped without a clear");
    alert_cause_a: assert property (alert_out |-> $past(alert_enable_in) && (st & ~$past(st)) != '0)
        else $error("alert without a newly set status bit");
    alert_due_a: assert property ($past(alert_enable_in) && (st & ~$past(st)) != '0 |-> alert_out)
        else $error("new status bit gave no alert");
    log_kind_a: assert property (log_write_out |-> log_kind_out != '0)
        else $error("log pulse without a kind");
    ot_sensor_a: assert property (log_write_out |-> log_kind_out[3] == (log_sensor_out != '0))
        else $error("sensor field disagrees with kind");
    alarm_quiet_a: assert property (inputs_quiet |=> !first_alarm_out && !second_alarm_out)
        else $error("alarm with no fault or warning");
    shut_now_a: assert property ($rose(primary_group_fault_out) && immediate_off_in |->
        (supply_enable_out & gm) == '0)
        else $error("global supply left on at group fault");
    fault_cause_a: assert property ($rose(primary_group_fault_out) || $rose(secondary_group_fault_pin_out) |->
        st != '0)
        else $error("group fault without a status bit");
    no_restart_a: assert property (fault_held |-> (supply_enable_out & ~$past(supply_enable_out) & gm) == '0)
        else $error("global supply restarted under group fault");
endmodule

// ==== supply_model.sv ====
`timescale 1ns/10ps
// supplies and their turn-off timers beyond the enables
module supply_model
    import fault_resp_pkg::*;
#(
    parameter int off_step = 40
)
(
    input wire logic ref_clk_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] supply_enable_in,
    input wire logic [fault_resp_pkg::num_chan-1:0] secondary_group_in,
    input wire logic primary_fault_in,
    input wire logic secondary_fault_in,
    output logic [fault_resp_pkg::num_chan-1:0] off_sequence_done_out
);
    int cnt [num_chan]; // cycles into each turn-off
    logic [num_chan-1:0] going; // supply off or its group shutting down
    // higher channels take longer, so the last global one ends last
    always_comb
    begin
        for (int c = 0; c < num_chan; c++)
        begin
            going[c] = !supply_enable_in[c] || (secondary_group_in[c] ? secondary_fault_in : primary_fault_in);
            off_sequence_done_out[c] = going[c] && cnt[c] >= off_step * (c + 1);
        end
    end
    // count while turning off, restart once back up
    always @(posedge ref_clk_in)
    begin
        for (int c = 0; c < num_chan; c++)
        begin
            cnt[c] <= going[c] ? cnt[c] + 1 : 0;
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
    import fault_resp_pkg::*;
    logic clk = 1'b0, rstn, imm, aen, clr, pf, sf, a0, a1, alert, lw; // controls and pins
    logic [15:0] rdly; // retry delay in ticks
    logic [15:0] w [num_chan]; // response word per channel
    logic [16*num_chan-1:0] word;
    logic [num_chan-1:0] sec, ovf, ovw, uvf, uvw, sqf, req, done, en, lc, ovs, uvs, sqs, lchan;
    logic [num_temp-1:0] otf, ls, ots, lsens;
    logic [3:0] lk, lkind;
    logic [11:0] r;
    int n_fail, n_compared, n_log, n_alert, k, t;
    // alarm rows: config, {ov f, ov w, uv f, uv w}, {seq f, 0, alarm 1, alarm 0}
    logic [11:0] rows [21] = '{12'h0f8, 12'h109, 12'h1f0, 12'h221, 12'h210, 12'h311, 12'h481,
        12'h460, 12'h541, 12'h621, 12'h650, 12'h711, 12'h8f8, 12'h90a, 12'ha22, 12'hb12,
        12'hc82, 12'hd42, 12'he82, 12'hf42, 12'hf08};
    always #2.5 clk = ~clk;
    always_comb for (int c = 0; c < num_chan; c++) word[16*c+:16] = w[c];
    // count log pulses and alerts, keep the last entry
    always @(posedge clk)
    begin
        n_log += lw;
        n_alert += alert;
        if (lw)
            {lkind, lchan, lsens} = {lk, lc, ls};
    end
    supply_fault_response_alarm DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .channel_response_word_in(word),
        .retry_delay_setting_in(rdly), .immediate_off_in(imm), .alert_enable_in(aen),
        .clear_faults_in(clr), .secondary_group_in(sec), .ov_fault_in(ovf), .ov_warn_in(ovw),
        .uv_fault_in(uvf), .uv_warn_in(uvw), .seq_fault_in(sqf), .ot_fault_in(otf),
        .supply_request_in(req), .off_sequence_done_in(done), .supply_enable_out(en),
        .primary_group_fault_out(pf), .secondary_group_fault_pin_out(sf), .first_alarm_out(a0),
        .second_alarm_out(a1), .alert_out(alert), .log_write_out(lw), .log_kind_out(lk),
        .log_chan_out(lc), .log_sensor_out(ls), .ov_status_out(ovs), .uv_status_out(uvs),
        .seq_status_out(sqs), .ot_status_out(ots));
    supply_model supplies (.ref_clk_in(clk), .supply_enable_in(en), .secondary_group_in(sec),
        .primary_fault_in(pf), .secondary_fault_in(sf), .off_sequence_done_out(done));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one clear-faults pulse
    task automatic clear();
        clr = 1'b1;
        cyc(1);
        clr = 1'b0;
        cyc(1);
    endtask
    // raise one fault line for a while, then drop it
    task automatic hit(input int kind, input int b);
        case (kind)
            0: ovf[b] = 1'b1;
            1: uvf[b] = 1'b1;
            2: sqf[b] = 1'b1;
            default: otf[b] = 1'b1;
        endcase
        cyc(8);
        {ovf, uvf, sqf} = '0;
        otf = '0;
        cyc(6);
    endtask
    // global retry from channel 6; t counts from group fault to restart
    task automatic retry_run();
        ovf[6] = 1'b1;
        t = 0;
        while (!pf && t < 20)
        begin
            cyc(1);
            t++;
        end
        ovf[6] = 1'b0;
        if (imm)
            chk(en[8:6], 3'h4);
        t = 0;
        while ((pf || !en[6]) && t < 2000)
        begin
            cyc(1);
            t++;
            if (t == 100)
                chk(pf, 1);
        end
        chk(pf, 0);
    endtask
    task automatic results();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {rstn, clr, aen, imm, rdly, sec, ovf, ovw, uvf, uvw, sqf, otf} = '0;
        {n_fail, n_compared} = '0;
        req = '1;
        w = '{default: 16'h0000};
        aen = 1'b1;
        imm = 1'b1;
        rdly = 16'h0001;
        cyc(10);
        rstn = 1'b1;
        cyc(4);
        chk(ovs | uvs | sqs, 0);
        chk({pf, sf, a0, a1, alert, lw, ots}, 0);
        n_log = 0;
        foreach (rows[i])
        begin
            r = rows[i];
            w[0] = {4'h0, r[11:8], 8'h00};
            {ovf[0], ovw[0], uvf[0], uvw[0], sqf[0]} = r[7:3];
            cyc(5);
            chk({a1, a0}, r[1:0]);
            {ovf[0], ovw[0], uvf[0], uvw[0], sqf[0]} = 5'h00;
            cyc(5);
        end
        chk(n_log, 0);
        clear();
        chk(ovs | uvs | sqs, 0);
        aen = 1'b0;
        w[0] = 16'h8000;
        k = n_alert;
        hit(0, 0);
        chk({n_log[3:0], ovs[0], pf, en[0]}, 7'h05);
        chk(n_alert, k);
        aen = 1'b1;
        w[0] = 16'h0000;
        w[2] = 16'hc003;
        hit(0, 2);
        chk({lkind, lchan, pf, en[2]}, {4'h1, 12'h004, 2'h1});
        chk(n_alert, k + 1);
        hit(0, 2);
        chk(n_log, 1);
        clear();
        chk(ovs[2], 0);
        hit(0, 2);
        chk(n_log, 2);
        w[2] = 16'h0000;
        w[3] = 16'h800c;
        n_log = 0;
        hit(1, 3);
        hit(1, 3);
        chk({n_log[3:0], uvs[3]}, 5'h03);
        req[3] = 1'b0;
        cyc(4);
        chk(en[3], 0);
        req[3] = 1'b1;
        cyc(4);
        hit(1, 3);
        chk(n_log, 2);
        w[3] = 16'h0000;
        w[4] = 16'h80c0;
        n_log = 0;
        hit(3, 0);
        chk({lkind, lsens, ots}, {4'h8, 5'h01, 5'h01});
        req[4] = 1'b0;
        cyc(4);
        req[4] = 1'b1;
        cyc(4);
        hit(3, 0);
        chk(n_log, 1);
        hit(3, 1);
        chk({n_log[3:0], lsens}, {4'h2, 5'h02});
        clear();
        hit(3, 0);
        chk(n_log, 3);
        w[4] = 16'h0000;
        w[5] = 16'h8030;
        n_log = 0;
        hit(2, 5);
        hit(2, 5);
        chk({n_log[3:0], lkind, sqs[5]}, 9'h049);
        w[5] = 16'h0000;
        w[6] = 16'hc002;
        w[7] = 16'h4000;
        retry_run();
        chk(t >= 200 && t < 450, 1);
        imm = 1'b0;
        clear();
        retry_run();
        chk(t > 500 && t < 1000, 1);
        imm = 1'b1;
        {w[6], w[7]} = '0;
        w[9] = 16'hc001;
        w[10] = 16'h4000;
        sec = 12'h600;
        clear();
        hit(0, 9);
        chk({pf, sf, en[10:8]}, 5'h09);
        chk({lkind, lchan, ovs[9]}, {4'h1, 12'h200, 1'b1});
        cyc(600);
        chk({sf, en[10:9]}, 3'h4);
        results();
    end
    initial
    begin
        #150000;
        n_fail++;
        results();
    end
endmodule
bind supply_fault_response_alarm sfra_properties u_chk (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .channel_response_word_in(channel_response_word_in), .immediate_off_in(immediate_off_in),
    .alert_enable_in(alert_enable_in), .clear_faults_in(clear_faults_in), .secondary_group_in(secondary_group_in),
    .ov_fault_in(ov_fault_in), .ov_warn_in(ov_warn_in), .uv_fault_in(uv_fault_in), .uv_warn_in(uv_warn_in),
    .seq_fault_in(seq_fault_in), .supply_enable_out(supply_enable_out), .alert_out(alert_out),
    .primary_group_fault_out(primary_group_fault_out), .first_alarm_out(first_alarm_out),
    .secondary_group_fault_pin_out(secondary_group_fault_pin_out), .second_alarm_out(second_alarm_out),
    .log_write_out(log_write_out), .log_kind_out(log_kind_out), .log_chan_out(log_chan_out),
    .log_sensor_out(log_sensor_out), .ov_status_out(ov_status_out), .uv_status_out(uv_status_out),
    .seq_status_out(seq_status_out), .ot_status_out(ot_status_out));
